/* File: shared/serial_mode_pkg.sv */
`default_nettype none
package serial_mode_pkg;

  // Register byte addresses
  localparam logic [7:0] CTRL_TWO_OFS   = 8'h10;
  localparam logic [7:0] CTRL_THREE_OFS = 8'h14;

  // Reset values
  localparam logic [31:0] CTRL_TWO_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL_THREE_RST = 32'h0000_0000;

  // Writable bit masks, reserved bits stay zero
  localparam logic [31:0] CTRL_TWO_MASK   = 32'h0000_7f6f;
  localparam logic [31:0] CTRL_THREE_MASK = 32'h0000_01ff;
  localparam logic [31:0] CTRL_TWO_LITE   = 32'h0000_4867;
  localparam logic [31:0] CTRL_THREE_LITE = 32'h0000_000f;

  // Control two fields
  localparam int NODE_ADDR_LSB    = 0;
  localparam int BREAK_LEN_BIT    = 5;
  localparam int BREAK_IRQ_BIT    = 6;
  localparam int LAST_PULSE_BIT   = 8;
  localparam int CLK_PHASE_BIT    = 9;
  localparam int CLK_POL_BIT      = 10;
  localparam int CLK_PIN_BIT      = 11;
  localparam int STOP_LSB         = 12;
  localparam int LIN_EN_BIT       = 14;

  // Control three fields
  localparam int ERR_IRQ_BIT      = 0;
  localparam int IR_EN_BIT        = 1;
  localparam int IR_LP_BIT        = 2;
  localparam int HALF_DUP_BIT     = 3;
  localparam int SC_NACK_BIT      = 4;
  localparam int SC_EN_BIT        = 5;
  localparam int DMA_RX_BIT       = 6;
  localparam int DMA_TX_BIT       = 7;
  localparam int RTS_EN_BIT       = 8;

  // Stop length codes, in half bits
  localparam logic [1:0] STOP_ONE      = 2'h0;
  localparam logic [1:0] STOP_HALF     = 2'h1;
  localparam logic [1:0] STOP_TWO      = 2'h2;
  localparam logic [1:0] STOP_ONE_HALF = 2'h3;
  localparam logic [2:0] HALVES_ONE      = 3'h2;
  localparam logic [2:0] HALVES_HALF     = 3'h1;
  localparam logic [2:0] HALVES_TWO      = 3'h4;
  localparam logic [2:0] HALVES_ONE_HALF = 3'h3;

  // Break thresholds in bit times
  localparam logic [3:0] BREAK_SHORT = 4'ha;
  localparam logic [3:0] BREAK_LONG  = 4'hb;

  // Mute states, one-hot
  typedef enum logic [1:0] {
    MUTE_OFF = 2'b01,
    MUTE_ON  = 2'b10
  } mute_state_t;

endpackage : serial_mode_pkg
`default_nettype wire

/* File: design/serial_port_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Mute mode compares address tag with node address
// - Break length bit selects 10 or 11 bits
// - Break interrupt only when its enable set
// - Last-bit pulse enable gates final clock pulse
// - Phase bit picks first or second edge
// - Polarity bit sets idle clock level
// - Clock pin enable gates clock pin drive
// - Stop field codes one, half, two, one-half
// - LIN enable switches LIN operation
// - Error interrupt needs enable, DMA receive, error
// - Infrared enable selects infrared line coding
// - Low-power bit picks infrared low-power mode
// - Half-duplex bit selects single-line operation
// - Smartcard NACK sent on parity error if enabled
// - Smartcard enable switches smartcard protocol
// - Receive DMA requests only when enabled
// - Transmit DMA requests only when enabled
// - RTS low while receive buffer has room, and always low while RTS enable is clear
// - Reduced instances omit node address bit 3, last pulse, phase, polarity, stop, smartcard, DMA, RTS
// - Both control registers reset to zero
// - Wakeup select: idle line or address tag
module serial_port_mode_control #(
  parameter bit FULL_FEATURE = 1'b1
) (
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Receiver and transmitter status
  input  wire logic        MUTE_REQ_I,
  input  wire logic        WAKE_ON_TAG_I,
  input  wire logic        IDLE_LINE_I,
  input  wire logic        ADDR_TAG_VALID_I,
  input  wire logic [3:0]  ADDR_TAG_I,
  input  wire logic        BREAK_DETECTED_FLAG_I,
  input  wire logic        FRAMING_ERROR_FLAG_I,
  input  wire logic        OVERRUN_ERROR_FLAG_I,
  input  wire logic        NOISE_ERROR_FLAG_I,
  input  wire logic        PARITY_ERROR_I,
  input  wire logic        RX_DATA_READY_I,
  input  wire logic        TX_SPACE_I,
  input  wire logic        RX_ROOM_I,
  input  wire logic        TX_ENABLE_I,
  // Synchronous clock request from the shifter
  input  wire logic        SHIFT_CLK_I,
  input  wire logic        SHIFT_ACTIVE_I,
  input  wire logic        LAST_BIT_I,
  // Mode outputs
  output logic             RECEIVE_MUTE_O,
  output logic [3:0]       BREAK_THRESHOLD_O,
  output logic [2:0]       STOP_HALVES_O,
  output logic             LIN_MODE_O,
  output logic             INFRARED_MODE_O,
  output logic             INFRARED_LOW_POWER_O,
  output logic             HALF_DUPLEX_O,
  output logic             SMARTCARD_MODE_O,
  output logic             SAMPLE_SECOND_EDGE_O,
  // Events and requests
  output logic             BREAK_IRQ_O,
  output logic             ERROR_IRQ_O,
  output logic             NACK_SEND_O,
  output logic             DMA_RX_REQ_O,
  output logic             DMA_TX_REQ_O,
  output logic             RTS_N_O,
  // Serial clock pin
  output logic             SERIAL_CLOCK_OUTPUT_O,
  output logic             SERIAL_CLOCK_OE_O
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0]                     ctrl_two;
    logic [31:0]                     ctrl_three;
    logic [31:0]                     rdata;
    serial_mode_pkg::mute_state_t    mute;
    logic                            brk_irq;
    logic                            err_irq;
    logic                            nack;
    logic                            dma_rx;
    logic                            dma_tx;
    logic                            rts_n;
    logic                            sclk;
    logic                            sclk_oe;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Reduced instances keep only the shared bits
  function automatic logic [31:0] wr_mask(input logic two);
    if (two)
      wr_mask = FULL_FEATURE ? serial_mode_pkg::CTRL_TWO_MASK
                             : serial_mode_pkg::CTRL_TWO_LITE;
    else
      wr_mask = FULL_FEATURE ? serial_mode_pkg::CTRL_THREE_MASK
                             : serial_mode_pkg::CTRL_THREE_LITE;
  endfunction : wr_mask

  function automatic logic [2:0] stop_halves(input logic [1:0] code);
    case (code)
      serial_mode_pkg::STOP_ONE:  stop_halves = serial_mode_pkg::HALVES_ONE;
      serial_mode_pkg::STOP_HALF: stop_halves = serial_mode_pkg::HALVES_HALF;
      serial_mode_pkg::STOP_TWO:  stop_halves = serial_mode_pkg::HALVES_TWO;
      default:                    stop_halves = serial_mode_pkg::HALVES_ONE_HALF;
    endcase
  endfunction : stop_halves

  //////////////////////////////////////////////////////////////////////////////
  // Field views

  logic        wr_two;
  logic        wr_three;
  logic [3:0]  node_addr;
  logic        wake_on_tag;
  logic        brk_len;
  logic        brk_ien;
  logic        last_pulse;
  logic        cpha;
  logic        clock_polarity;
  logic        clk_pin;
  logic        lin_en;
  logic        err_ien;
  logic        sc_nack;
  logic        sc_en;
  logic        dma_rx_en;
  logic        dma_tx_en;
  logic        rts_en;

  assign node_addr   = st_r.ctrl_two[serial_mode_pkg::NODE_ADDR_LSB +: 4];
  assign brk_len     = st_r.ctrl_two[serial_mode_pkg::BREAK_LEN_BIT];
  assign brk_ien     = st_r.ctrl_two[serial_mode_pkg::BREAK_IRQ_BIT];
  assign last_pulse  = st_r.ctrl_two[serial_mode_pkg::LAST_PULSE_BIT];
  assign cpha        = st_r.ctrl_two[serial_mode_pkg::CLK_PHASE_BIT];
  assign clock_polarity        = st_r.ctrl_two[serial_mode_pkg::CLK_POL_BIT];
  assign clk_pin     = st_r.ctrl_two[serial_mode_pkg::CLK_PIN_BIT];
  assign lin_en      = st_r.ctrl_two[serial_mode_pkg::LIN_EN_BIT];
  assign err_ien     = st_r.ctrl_three[serial_mode_pkg::ERR_IRQ_BIT];
  assign sc_nack     = st_r.ctrl_three[serial_mode_pkg::SC_NACK_BIT];
  assign sc_en       = st_r.ctrl_three[serial_mode_pkg::SC_EN_BIT];
  assign dma_rx_en   = st_r.ctrl_three[serial_mode_pkg::DMA_RX_BIT];
  assign dma_tx_en   = st_r.ctrl_three[serial_mode_pkg::DMA_TX_BIT];
  assign rts_en      = st_r.ctrl_three[serial_mode_pkg::RTS_EN_BIT];
  // Wakeup method lives outside these registers, so it is a free pin
  assign wake_on_tag = WAKE_ON_TAG_I;

  assign wr_two   = PSEL_I && PENABLE_I && PWRITE_I
                    && (PADDR_I == serial_mode_pkg::CTRL_TWO_OFS);
  assign wr_three = PSEL_I && PENABLE_I && PWRITE_I
                    && (PADDR_I == serial_mode_pkg::CTRL_THREE_OFS);

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_nxt = st_r;

    // Register writes, single-cycle access
    if (wr_two)
      st_nxt.ctrl_two = PWDATA_I & wr_mask(1'b1);
    if (wr_three)
      st_nxt.ctrl_three = PWDATA_I & wr_mask(1'b0);

    // Read data captured in setup so it is valid in access
    if (PSEL_I && !PENABLE_I)
    begin
      if (PADDR_I == serial_mode_pkg::CTRL_TWO_OFS)
        st_nxt.rdata = st_r.ctrl_two;
      else if (PADDR_I == serial_mode_pkg::CTRL_THREE_OFS)
        st_nxt.rdata = st_r.ctrl_three;
      else
        st_nxt.rdata = 32'h0000_0000;
    end

    // Mute control
    case (st_r.mute)
      serial_mode_pkg::MUTE_OFF:
      begin
        if (MUTE_REQ_I)
          st_nxt.mute = serial_mode_pkg::MUTE_ON;
      end
      serial_mode_pkg::MUTE_ON:
      begin
        if (wake_on_tag)
        begin
          if (ADDR_TAG_VALID_I && ADDR_TAG_I == node_addr)
            st_nxt.mute = serial_mode_pkg::MUTE_OFF;
        end
        else if (IDLE_LINE_I)
          st_nxt.mute = serial_mode_pkg::MUTE_OFF;
      end
      default:
        st_nxt.mute = serial_mode_pkg::MUTE_OFF;
    endcase

    // Interrupts follow the flags while enabled
    st_nxt.brk_irq = brk_ien && BREAK_DETECTED_FLAG_I;
    st_nxt.err_irq = err_ien && dma_rx_en
                     && (FRAMING_ERROR_FLAG_I || OVERRUN_ERROR_FLAG_I
                         || NOISE_ERROR_FLAG_I);
    st_nxt.nack    = sc_en && sc_nack && PARITY_ERROR_I;
    st_nxt.dma_rx  = dma_rx_en && RX_DATA_READY_I;
    st_nxt.dma_tx  = dma_tx_en && TX_SPACE_I;
    st_nxt.rts_n   = rts_en ? !RX_ROOM_I : 1'b0;

    // Serial clock: idle at polarity, last pulse optional
    st_nxt.sclk_oe = clk_pin;
    if (SHIFT_ACTIVE_I && (!LAST_BIT_I || last_pulse))
      st_nxt.sclk = SHIFT_CLK_I ^ clock_polarity;
    else
      st_nxt.sclk = clock_polarity;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      st_r            <= '0;
      st_r.ctrl_two   <= serial_mode_pkg::CTRL_TWO_RST;
      st_r.ctrl_three <= serial_mode_pkg::CTRL_THREE_RST;
      st_r.mute       <= serial_mode_pkg::MUTE_OFF;
    end
    else
      st_r <= st_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign PRDATA_O  = st_r.rdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = 1'b0;

  assign RECEIVE_MUTE_O       = (st_r.mute == serial_mode_pkg::MUTE_ON);
  assign BREAK_THRESHOLD_O    = brk_len ? serial_mode_pkg::BREAK_LONG
                                        : serial_mode_pkg::BREAK_SHORT;
  assign STOP_HALVES_O        = stop_halves(
    st_r.ctrl_two[serial_mode_pkg::STOP_LSB +: 2]);
  assign LIN_MODE_O           = lin_en;
  assign INFRARED_MODE_O      = st_r.ctrl_three[serial_mode_pkg::IR_EN_BIT];
  assign INFRARED_LOW_POWER_O = st_r.ctrl_three[serial_mode_pkg::IR_LP_BIT];
  assign HALF_DUPLEX_O        = st_r.ctrl_three[serial_mode_pkg::HALF_DUP_BIT];
  assign SMARTCARD_MODE_O     = sc_en;
  assign SAMPLE_SECOND_EDGE_O = cpha;

  assign BREAK_IRQ_O  = st_r.brk_irq;
  assign ERROR_IRQ_O  = st_r.err_irq;
  assign NACK_SEND_O  = st_r.nack;
  assign DMA_RX_REQ_O = st_r.dma_rx;
  assign DMA_TX_REQ_O = st_r.dma_tx;
  assign RTS_N_O      = st_r.rts_n;

  // Clock settings are taken live; changing them mid-frame glitches the pin
  assign SERIAL_CLOCK_OUTPUT_O = st_r.sclk;
  assign SERIAL_CLOCK_OE_O     = st_r.sclk_oe;

  // TX enable is status only, kept for a future write lock
  logic unused_tx_en;
  assign unused_tx_en = TX_ENABLE_I;

endmodule : serial_port_mode_control
`default_nettype wire

/* File: tb/line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Remote line side: status flags change only after a clock edge
module line_partner (
  // Clock
  input  wire logic       clk,
  // Wanted line state: brk, fe, ov, ne, pe, rdy, spc, room
  input  wire logic [7:0] cmd,
  // Status toward the block
  output logic [7:0]      flags
);
  always_ff @(posedge clk)
  begin
    flags <= cmd;
  end
endmodule : line_partner
`default_nettype wire

/* File: tb/serial_port_mode_control_checker.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module mode_checker (
  input wire logic       MCLK_I,
  input wire logic       RST_I,
  input wire logic       PREADY_O,
  input wire logic       PSLVERR_O,
  input wire logic       BREAK_DETECTED_FLAG_I,
  input wire logic       FRAMING_ERROR_FLAG_I,
  input wire logic       OVERRUN_ERROR_FLAG_I,
  input wire logic       NOISE_ERROR_FLAG_I,
  input wire logic       PARITY_ERROR_I,
  input wire logic       RX_DATA_READY_I,
  input wire logic       TX_SPACE_I,
  input wire logic       RX_ROOM_I,
  input wire logic       BREAK_IRQ_O,
  input wire logic       ERROR_IRQ_O,
  input wire logic       NACK_SEND_O,
  input wire logic       DMA_RX_REQ_O,
  input wire logic       DMA_TX_REQ_O,
  input wire logic       RTS_N_O,
  input wire logic [3:0] BREAK_THRESHOLD_O,
  input wire logic [2:0] STOP_HALVES_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // Events lag their cause by exactly one edge
  brk_irq_a: assert property (
    BREAK_IRQ_O |-> $past(BREAK_DETECTED_FLAG_I)) else $error("break irq");
  err_irq_a: assert property (
    ERROR_IRQ_O |-> $past(FRAMING_ERROR_FLAG_I || OVERRUN_ERROR_FLAG_I
    || NOISE_ERROR_FLAG_I)) else $error("error irq without flag");
  nack_send_a: assert property (
    NACK_SEND_O |-> $past(PARITY_ERROR_I)) else $error("nack without error");
  dma_rx_a: assert property (
    DMA_RX_REQ_O |-> $past(RX_DATA_READY_I)) else $error("rx dma request");
  dma_tx_a: assert property (
    DMA_TX_REQ_O |-> $past(TX_SPACE_I)) else $error("tx dma request");
  rts_room_a: assert property (
    $past(RX_ROOM_I) |-> !RTS_N_O) else $error("rts high with room");
  break_len_a: assert property (
    BREAK_THRESHOLD_O inside {4'ha, 4'hb}) else $error("break threshold");
  stop_len_a: assert property (
    STOP_HALVES_O inside {[3'h1:3'h4]}) else $error("stop length");
  apb_ready_a: assert property (
    PREADY_O && !PSLVERR_O) else $error("apb answer");
endmodule : mode_checker
bind serial_port_mode_control mode_checker i_mode_checker (.*);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module testbench;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] padr = 8'h00, cmd = 8'h00, fl;
  logic [31:0] pwd = 32'h0, q, prd;
  logic mute = 1'b0, idle = 1'b0, tv = 1'b0, wake = 1'b0;
  logic [3:0] tag = 4'h0, brk;
  logic [2:0] stp;
  logic rdy, err_o, muted, lin, ir, irlp, hd, sc, sec, bi, ei, nk, dr, dt;
  logic rts_n, sclk, soe;
  logic sh_clk = 1'b0, sh_act = 1'b0, sh_last = 1'b0;
  int errors = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  line_partner i_line_partner (.clk(clk), .cmd(cmd), .flags(fl));
  serial_port_mode_control i_serial_port_mode_control (
    .MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(err_o), .MUTE_REQ_I(mute),
    .IDLE_LINE_I(idle), .ADDR_TAG_VALID_I(tv), .ADDR_TAG_I(tag),
    .WAKE_ON_TAG_I(wake), .BREAK_DETECTED_FLAG_I(fl[7]),
    .FRAMING_ERROR_FLAG_I(fl[6]), .OVERRUN_ERROR_FLAG_I(fl[5]),
    .NOISE_ERROR_FLAG_I(fl[4]), .PARITY_ERROR_I(fl[3]),
    .RX_DATA_READY_I(fl[2]), .TX_SPACE_I(fl[1]), .RX_ROOM_I(fl[0]),
    .TX_ENABLE_I(1'b0), .SHIFT_CLK_I(sh_clk), .SHIFT_ACTIVE_I(sh_act),
    .LAST_BIT_I(sh_last), .RECEIVE_MUTE_O(muted), .BREAK_THRESHOLD_O(brk),
    .STOP_HALVES_O(stp), .LIN_MODE_O(lin), .INFRARED_MODE_O(ir),
    .INFRARED_LOW_POWER_O(irlp), .HALF_DUPLEX_O(hd),
    .SMARTCARD_MODE_O(sc), .SAMPLE_SECOND_EDGE_O(sec), .BREAK_IRQ_O(bi),
    .ERROR_IRQ_O(ei), .NACK_SEND_O(nk), .DMA_RX_REQ_O(dr),
    .DMA_TX_REQ_O(dt), .RTS_N_O(rts_n), .SERIAL_CLOCK_OUTPUT_O(sclk),
    .SERIAL_CLOCK_OE_O(soe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Ceiling far above the roughly 125 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors = errors + 1;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Read data is taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; padr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = prd;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(0, 8'h10, 0); chk("two rst", q, 32'h0);
    apb(0, 8'h14, 0); chk("three rst", q, 32'h0);
    apb(1, 8'h10, 32'hffff_ffff); apb(0, 8'h10, 0);
    chk("two mask", q, 32'h0000_7f6f);
    chk("modes2", 32'({brk, lin, sec}), 32'h2f);
    apb(1, 8'h14, 32'hffff_ffff); apb(0, 8'h14, 0);
    chk("three mask", q, 32'h0000_01ff);
    chk("modes3", 32'({ir, irlp, hd, sc}), 32'hf);
    apb(1, 8'h18, 32'h1234_5678); apb(0, 8'h18, 0);
    chk("unmapped", q, 32'h0);
    apb(1, 8'h10, 0); apb(1, 8'h14, 0); tick(1);
    chk("off2", 32'({brk, lin, sec}), 32'h28);
    chk("off3", 32'({ir, irlp, hd, sc}), 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_stop;
    logic [2:0] ex [4] = '{3'h2, 3'h1, 3'h4, 3'h3};
    for (int i = 0; i < 4; i++)
    begin
      apb(1, 8'h10, 32'(i) << 12); tick(1);
      chk("stop", 32'(stp), 32'(ex[i]));
    end
    $display("stop done");
  endtask : t_stop
  task automatic t_events;
    apb(1, 8'h10, 32'h40); apb(1, 8'h14, 32'h1f1);
    cmd <= 8'hfe; tick(3);
    chk("events on", 32'({bi, ei, nk, dr, dt, rts_n}), 32'h3f);
    cmd <= 8'h01; tick(3);
    chk("events idle", 32'({bi, ei, nk, dr, dt, rts_n}), 32'h0);
    apb(1, 8'h10, 0); apb(1, 8'h14, 32'h1); cmd <= 8'hfe; tick(3);
    chk("events off", 32'({bi, ei, nk, dr, dt, rts_n}), 32'h0);
    cmd <= 8'h00;
    $display("events done");
  endtask : t_events
  task automatic t_mute;
    apb(1, 8'h10, 32'h5); wake <= 1'b1;
    mute <= 1'b1; tick(1); mute <= 1'b0; tick(3);
    chk("muted", 32'(muted), 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      tag <= i ? 4'h5 : 4'h3; tv <= 1'b1; tick(1); tv <= 1'b0; tick(3);
      chk("tag wake", 32'(muted), 32'(i == 0));
    end
    wake <= 1'b0; mute <= 1'b1; tick(1); mute <= 1'b0;
    tv <= 1'b1; tick(1); tv <= 1'b0; tick(3);
    chk("idle method", 32'(muted), 32'h1);
    idle <= 1'b1; tick(1); idle <= 1'b0; tick(3);
    chk("idle wake", 32'(muted), 32'h0);
    $display("mute done");
  endtask : t_mute
  task automatic t_sync;
    apb(1, 8'h10, 32'h0c00); tick(2);
    chk("clk high", 32'({soe, sclk}), 32'h3);
    apb(1, 8'h10, 32'h0800); tick(2);
    chk("clk low", 32'({soe, sclk}), 32'h2);
    // Clock settings only change while no frame is active
    apb(1, 8'h10, 32'h0900); sh_act <= 1'b1; sh_clk <= 1'b1;
    sh_last <= 1'b1; tick(2);
    chk("last pulse on", 32'(sclk), 32'h1);
    sh_act <= 1'b0; tick(1);
    apb(1, 8'h10, 32'h0800); sh_act <= 1'b1; tick(2);
    chk("last pulse off", 32'(sclk), 32'h0);
    sh_last <= 1'b0; tick(2);
    chk("mid pulse", 32'(sclk), 32'h1);
    sh_act <= 1'b0; sh_clk <= 1'b0; sh_last <= 1'b0; tick(1);
    apb(1, 8'h10, 0); tick(2);
    chk("clk off", 32'(soe), 32'h0);
    $display("sync done");
  endtask : t_sync
  initial
  begin
    tick(3);
    rst <= 1'b0;
    t_regs(); t_stop(); t_events(); t_mute(); t_sync();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
